// ==== rtl/adm_pkg.sv ====
/*
  adm_pkg: constants, field layouts and types shared by the auxiliary
  digital i/o mapper and its channel modules.
  assumes a single 100 MHz core clock and an APB register bus.
*/
package adm_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned US_PER_S        = 1_000_000;
  localparam int unsigned MS_CYCLES       = CLK_HZ / MS_PER_S;
  localparam int unsigned STROBE_WIDTH_US = 100;
  localparam int unsigned STROBE_CYCLES   =
    (CLK_HZ / US_PER_S) * STROBE_WIDTH_US;
  localparam int unsigned FILTER_MAX_MS   = 10_000_000;

  // sizes
  localparam int NUM_DIN   = 3;
  localparam int NUM_DOUT  = 4;
  localparam int FILT_W    = 24;
  localparam int ACT_W     = 4;
  localparam int NUM_COND  = 7;

  // register byte addresses
  localparam logic [7:0] ADDR_DOUT_CFG  = 8'h00;
  localparam logic [7:0] ADDR_DIN_FILT0 = 8'h04;
  localparam logic [7:0] DIN_FILT_STEP  = 8'h04;
  localparam logic [7:0] ADDR_DIN_ACT   = 8'h10;
  localparam logic [7:0] ADDR_CTRL      = 8'h14;
  localparam logic [7:0] ADDR_STATUS    = 8'h18;

  // output config field: per output one byte
  localparam int DOUT_FIELD_W = 8;
  localparam int DOUT_FUNC_W  = 4;
  localparam int DOUT_INV_BIT = 4;
  // action field: per input one byte, rising low nibble
  localparam int ACT_FIELD_W  = 8;
  localparam int ACT_FALL_LSB = 4;

  // control register bits
  localparam int CTRL_W         = 8;
  localparam int CTRL_STB_TRANS = 0;
  localparam int CTRL_STB_OUT   = 1;
  localparam int CTRL_STB_SRC   = 2;
  localparam int CTRL_RMT_LSB   = 3;
  localparam int CTRL_TRIG_EN   = 5;
  localparam int CTRL_TRIG_AUTO = 6;
  localparam int CTRL_TRIG_SKIP = 7;

  // status register bits
  localparam int STAT_DIN_LSB   = 0;
  localparam int STAT_DOUT_LSB  = 3;
  localparam int STAT_RELAY     = 7;
  localparam int STAT_PIN_LSB   = 8;

  // condition vector positions
  localparam int COND_FAULT    = 0;
  localparam int COND_PHASE    = 1;
  localparam int COND_OUTSTATE = 2;
  localparam int COND_PROGRAM  = 3;
  localparam int COND_REMOTE   = 4;
  localparam int COND_TRANS    = 5;
  localparam int COND_COUPLING = 6;

  // reset values: every output fixed low, nothing enabled
  localparam logic [31:0]       DOUT_CFG_RST = 32'h03030303;
  localparam logic [CTRL_W-1:0] CTRL_RST     = 8'h00;

  typedef enum logic [DOUT_FUNC_W-1:0] {
    FN_FAULT        = 4'h0,
    FN_PHASE_CONFIG = 4'h1,
    FN_HIGH         = 4'h2,
    FN_LOW          = 4'h3,
    FN_OUT_STATE    = 4'h4,
    FN_PROGRAM      = 4'h5,
    FN_REMOTE       = 4'h6,
    FN_TRANSIENT    = 4'h7,
    FN_COUPLING     = 4'h8
  } adm_func_e;

  typedef enum logic [1:0] {
    RMT_DISABLED = 2'h0,
    RMT_INHIBIT  = 2'h1,
    RMT_ENABLE   = 2'h2
  } adm_rmt_e;

endpackage

// ==== rtl/adm_din_filter.sv ====
/*
  adm_din_filter: one digital input channel; synchroniser, glitch filter
  in millisecond steps and edge pulses.
  assumes msTick is a one-cycle pulse once per millisecond.
*/
`timescale 1ns/1ps
module adm_din_filter
  import adm_pkg::*;
(
  input  wire logic              coreClk,
  input  wire logic              rst,
  input  wire logic              msTick,
  input  wire logic              pinIn,
  input  wire logic [FILT_W-1:0] filterMs,
  output logic                   level,
  output logic                   risePulse,
  output logic                   fallPulse
);

  typedef struct packed {
    logic              sync1;
    logic              sync2;
    logic              stable;
    logic              rise;
    logic              fall;
    logic [FILT_W-1:0] cnt;
  } adm_din_s;

  adm_din_s s;
  adm_din_s next_s;

  always_comb begin
    next_s       = s;
    next_s.sync1 = pinIn;
    next_s.sync2 = s.sync1;
    next_s.rise  = 1'b0;
    next_s.fall  = 1'b0;
    // a level must persist filterMs whole ticks before it is taken
    if (s.sync2 == s.stable) begin
      next_s.cnt = '0;
    end else if (s.cnt >= filterMs) begin
      next_s.stable = s.sync2;
      next_s.rise   = s.sync2;
      next_s.fall   = !s.sync2;
      next_s.cnt    = '0;
    end else if (msTick) begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge coreClk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level     = s.stable;
  assign risePulse = s.rise;
  assign fallPulse = s.fall;

endmodule // adm_din_filter

// ==== rtl/adm_dout_select.sv ====
/*
  adm_dout_select: one digital output channel; source selection and
  polarity inversion, registered.
  assumes condition inputs are levels on the core clock.
*/
`timescale 1ns/1ps
module adm_dout_select
  import adm_pkg::*;
(
  input  wire logic                   coreClk,
  input  wire logic                   rst,
  input  wire logic [DOUT_FUNC_W-1:0] func,
  input  wire logic                   invert,
  input  wire logic [NUM_COND-1:0]    cond,
  output logic                        level,
  output logic                        levelN
);

  typedef struct packed {
    logic lvl;
    logic lvlN;
  } adm_dout_s;

  adm_dout_s s;
  adm_dout_s next_s;
  logic      sel;

  always_comb begin
    unique case (adm_func_e'(func))
      FN_FAULT:        sel = cond[COND_FAULT];
      FN_PHASE_CONFIG: sel = cond[COND_PHASE];
      FN_HIGH:         sel = 1'b1;
      FN_LOW:          sel = 1'b0;
      FN_OUT_STATE:    sel = cond[COND_OUTSTATE];
      FN_PROGRAM:      sel = cond[COND_PROGRAM];
      FN_REMOTE:       sel = cond[COND_REMOTE];
      FN_TRANSIENT:    sel = cond[COND_TRANS];
      FN_COUPLING:     sel = cond[COND_COUPLING];
      default:         sel = 1'b0;
    endcase
    next_s.lvl  = sel ^ invert;
    next_s.lvlN = !(sel ^ invert);
  end

  always_ff @(posedge coreClk) begin
    if (rst) begin
      s <= '{lvl: 1'b0, lvlN: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign level  = s.lvl;
  assign levelN = s.lvlN;

endmodule // adm_dout_select

// ==== rtl/adm_io_mapper.sv ====
/*
  adm_io_mapper: auxiliary digital i/o of an ac power source; four
  selectable outputs, three filtered edge inputs, strobe output,
  remote relay control and trigger input, configured over APB.
  assumes all condition inputs come from logic on coreClk; pins are
  asynchronous and pass two flip-flops first.
*/
// Design decisions made here: the register offsets and register access over APB.
// Functional notes
// - each output selects one of nine sources
// - fault source: 1 while fault present
// - phase source: 1 single, 0 split/three
// - relay source: 1 when output enabled
// - program source: 1 steady program, 0 manual
// - remote source: 1 remote, 0 local
// - transient source: 1 running, paused, stepping
// - coupling source: 1 transformer, 0 direct
// - per-output invert flips value before pin
// - relay outputs: logic 1 pulls pin low
// - rising edge launches its own action
// - falling edge launches separate own action
// - filter time 0 to 10,000,000 ms
// - pulses shorter than filter are dropped
// - strobe pulses on transient start if enabled
// - strobe pulses on relay close if enabled
// - strobe pulses on parameter change if enabled
// - inhibit: relay closes only with contact closed
// - enable: contact or panel; disabled: ignored
// - trigger_auto_start: trigger starts transient without run
// - trigger_skip_phase: trigger start ignores phase angle
`timescale 1ns/1ps
module adm_io_mapper
  import adm_pkg::*;
#(
  parameter int unsigned MS_CYCLES_P     = MS_CYCLES,
  parameter int unsigned STROBE_CYCLES_P = STROBE_CYCLES
) (
  input  wire logic                      coreClk,
  input  wire logic                      rst,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // unit conditions
  input  wire logic                      faultActive,
  input  wire logic                      singlePhase,
  input  wire logic                      outputEnabled,
  input  wire logic                      programActive,
  input  wire logic                      remoteActive,
  input  wire logic                      transientActive,
  input  wire logic                      transformerCoupled,
  input  wire logic                      transientStart,
  input  wire logic                      paramChange,
  input  wire logic                      frontPanelRelay,
  input  wire logic                      transientArmed,
  // pins
  input  wire logic [NUM_DIN-1:0]        digInPin,
  input  wire logic                      remoteContactPin,
  input  wire logic                      trigInPin,
  output logic                           logicLevelOutA,
  output logic                           logicLevelOutB,
  input  wire logic                      relayDriveOutAIn,
  output logic                           relayDriveOutAOut,
  output logic                           relayDriveOutAOeN,
  input  wire logic                      relayDriveOutBIn,
  output logic                           relayDriveOutBOut,
  output logic                           relayDriveOutBOeN,
  output logic                           strobeOut,
  // actions and control towards the unit
  output logic      [NUM_DIN-1:0]        actRise,
  output logic      [NUM_DIN-1:0]        actFall,
  output logic      [NUM_DIN*ACT_W-1:0]  riseAction,
  output logic      [NUM_DIN*ACT_W-1:0]  fallAction,
  output logic                           relayClose,
  output logic                           trigRun,
  output logic                           trigSkipPhase
);

  localparam int MS_W  = $clog2(MS_CYCLES_P + 1);
  localparam int STB_W = $clog2(STROBE_CYCLES_P + 1);
  localparam logic [MS_W-1:0]  MS_LAST  = MS_W'(MS_CYCLES_P - 1);
  localparam logic [STB_W-1:0] STB_LAST = STB_W'(STROBE_CYCLES_P - 1);

  typedef struct packed {
    logic [31:0]                   doutCfg;
    logic [NUM_DIN-1:0][FILT_W-1:0] filt;
    logic [NUM_DIN*ACT_FIELD_W-1:0] act;
    logic [CTRL_W-1:0]             ctrl;
    logic [31:0]                   rdata;
    logic                          ready;
    logic                          slverr;
    logic [MS_W-1:0]               msCnt;
    logic                          msTick;
    logic [STB_W-1:0]              stbCnt;
    logic                          strobe;
    logic                          outEnPrev;
    logic                          trigS1;
    logic                          trigS2;
    logic                          trigPrev;
    logic                          rmtS1;
    logic                          rmtS2;
    logic [1:0]                    pinS1;
    logic [1:0]                    pinS2;
    logic                          relay;
    logic                          run;
    logic                          skip;
  } adm_top_state_s;

  adm_top_state_s s;
  adm_top_state_s next_s;

  logic [NUM_DIN-1:0]  dinLevel;
  logic [NUM_DOUT-1:0] doutLevel;
  logic [NUM_DOUT-1:0] doutLevelN;
  logic [NUM_COND-1:0] cond;
  logic [31:0]         statusWord;
  logic [31:0]         rdMux;
  logic                addrHit;
  logic                stbEvent;
  logic                trigEdge;
  adm_rmt_e            rmtMode;

  function automatic logic [31:0] mergeStrb(input logic [31:0] oldV,
                                            input logic [31:0] newV,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = oldV;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = newV[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] filtAddr(input int i);
    return 8'(ADDR_DIN_FILT0 + DIN_FILT_STEP * 8'(i));
  endfunction

  // condition vector shared by all output channels
  assign cond[COND_FAULT]    = faultActive;
  assign cond[COND_PHASE]    = singlePhase;
  assign cond[COND_OUTSTATE] = outputEnabled;
  assign cond[COND_PROGRAM]  = programActive;
  assign cond[COND_REMOTE]   = remoteActive;
  assign cond[COND_TRANS]    = transientActive;
  assign cond[COND_COUPLING] = transformerCoupled;

  genvar g;
  generate
    for (g = 0; g < NUM_DIN; g++) begin : gDin
      adm_din_filter uDin (
        .coreClk   (coreClk),
        .rst       (rst),
        .msTick    (s.msTick),
        .pinIn     (digInPin[g]),
        .filterMs  (s.filt[g]),
        .level     (dinLevel[g]),
        .risePulse (actRise[g]),
        .fallPulse (actFall[g])
      );
      assign riseAction[g*ACT_W +: ACT_W] =
        s.act[g*ACT_FIELD_W +: ACT_W];
      assign fallAction[g*ACT_W +: ACT_W] =
        s.act[g*ACT_FIELD_W + ACT_FALL_LSB +: ACT_W];
    end
    for (g = 0; g < NUM_DOUT; g++) begin : gDout
      adm_dout_select uDout (
        .coreClk (coreClk),
        .rst     (rst),
        .func    (s.doutCfg[g*DOUT_FIELD_W +: DOUT_FUNC_W]),
        .invert  (s.doutCfg[g*DOUT_FIELD_W + DOUT_INV_BIT]),
        .cond    (cond),
        .level   (doutLevel[g]),
        .levelN  (doutLevelN[g])
      );
    end
  endgenerate

  always_comb begin
    statusWord = '0;
    statusWord[STAT_DIN_LSB +: NUM_DIN]   = dinLevel;
    statusWord[STAT_DOUT_LSB +: NUM_DOUT] = doutLevel;
    statusWord[STAT_RELAY]                = s.relay;
    statusWord[STAT_PIN_LSB +: 2]         = s.pinS2;
  end

  // read decode; unmapped addresses answer zero with an error
  always_comb begin
    rdMux   = '0;
    addrHit = 1'b1;
    if (paddr == ADDR_DOUT_CFG) begin
      rdMux = s.doutCfg;
    end else if (paddr == ADDR_DIN_ACT) begin
      rdMux = 32'(s.act);
    end else if (paddr == ADDR_CTRL) begin
      rdMux = 32'(s.ctrl);
    end else if (paddr == ADDR_STATUS) begin
      rdMux = statusWord;
    end else begin
      addrHit = 1'b0;
      for (int i = 0; i < NUM_DIN; i++) begin
        if (paddr == filtAddr(i)) begin
          rdMux   = 32'(s.filt[i]);
          addrHit = 1'b1;
        end
      end
    end
  end

  assign rmtMode  = adm_rmt_e'(s.ctrl[CTRL_RMT_LSB +: 2]);
  assign trigEdge = s.trigS2 && !s.trigPrev;
  assign stbEvent =
    (s.ctrl[CTRL_STB_TRANS] && transientStart) ||
    (s.ctrl[CTRL_STB_OUT] && outputEnabled && !s.outEnPrev) ||
    (s.ctrl[CTRL_STB_SRC] && paramChange);

  always_comb begin
    logic [31:0] w;
    next_s = s;
    w      = '0;

    // apb: answer is prepared in the setup cycle, zero wait states
    next_s.ready  = 1'b0;
    next_s.slverr = 1'b0;
    if (psel && !penable) begin
      next_s.ready  = 1'b1;
      next_s.rdata  = addrHit ? rdMux : '0;
      next_s.slverr = !addrHit;
    end
    if (psel && penable && s.ready && pwrite) begin
      if (paddr == ADDR_DOUT_CFG) begin
        next_s.doutCfg = mergeStrb(s.doutCfg, pwdata, pstrb);
      end else if (paddr == ADDR_DIN_ACT) begin
        w          = mergeStrb(32'(s.act), pwdata, pstrb);
        next_s.act = w[NUM_DIN*ACT_FIELD_W-1:0];
      end else if (paddr == ADDR_CTRL) begin
        w           = mergeStrb(32'(s.ctrl), pwdata, pstrb);
        next_s.ctrl = w[CTRL_W-1:0];
      end
      for (int i = 0; i < NUM_DIN; i++) begin
        if (paddr == filtAddr(i)) begin
          w              = mergeStrb(32'(s.filt[i]), pwdata, pstrb);
          next_s.filt[i] = w[FILT_W-1:0];
        end
      end
    end

    // millisecond tick for the input filters
    next_s.msTick = 1'b0;
    if (s.msCnt == MS_LAST) begin
      next_s.msCnt  = '0;
      next_s.msTick = 1'b1;
    end else begin
      next_s.msCnt = s.msCnt + 1'b1;
    end

    // strobe: fixed-width pulse, a new event restarts it
    next_s.outEnPrev = outputEnabled;
    if (stbEvent) begin
      next_s.strobe = 1'b1;
      next_s.stbCnt = STB_LAST;
    end else if (s.stbCnt != '0) begin
      next_s.stbCnt = s.stbCnt - 1'b1;
    end else begin
      next_s.strobe = 1'b0;
    end

    // pin synchronisers
    next_s.trigS1   = trigInPin;
    next_s.trigS2   = s.trigS1;
    next_s.trigPrev = s.trigS2;
    next_s.rmtS1    = remoteContactPin;
    next_s.rmtS2    = s.rmtS1;
    next_s.pinS1    = {relayDriveOutBIn, relayDriveOutAIn};
    next_s.pinS2    = s.pinS1;

    // output relay permission
    unique case (rmtMode)
      RMT_INHIBIT: next_s.relay = frontPanelRelay && s.rmtS2;
      RMT_ENABLE:  next_s.relay = frontPanelRelay || s.rmtS2;
      RMT_DISABLED: next_s.relay = frontPanelRelay;
      default:     next_s.relay = frontPanelRelay;
    endcase

    // trigger input starts a transient
    next_s.run = trigEdge && s.ctrl[CTRL_TRIG_EN] &&
                 (s.ctrl[CTRL_TRIG_AUTO] || transientArmed);
    if (next_s.run) begin
      next_s.skip = s.ctrl[CTRL_TRIG_SKIP];
    end
  end

  always_ff @(posedge coreClk) begin
    if (rst) begin
      s         <= '0;
      s.doutCfg <= DOUT_CFG_RST;
      s.ctrl    <= CTRL_RST;
    end else begin
      s <= next_s;
    end
  end

  assign prdata         = s.rdata;
  assign pready         = s.ready;
  assign pslverr        = s.slverr;
  assign logicLevelOutA = doutLevel[0];
  assign logicLevelOutB = doutLevel[1];
  // open drain: pin only ever pulled low, enable low while pulling
  assign relayDriveOutAOut = 1'b0;
  assign relayDriveOutBOut = 1'b0;
  assign relayDriveOutAOeN = doutLevelN[2];
  assign relayDriveOutBOeN = doutLevelN[3];
  assign strobeOut      = s.strobe;
  assign relayClose     = s.relay;
  assign trigRun        = s.run;
  assign trigSkipPhase  = s.skip;

endmodule // adm_io_mapper

// ==== bench/adm_io_mapper_props.sv ====
/*
  adm_io_mapper_props: port assertions for adm_io_mapper, bound in.
  assumes synchronous active-high reset and registered outputs.
*/
`timescale 1ns/1ps
module adm_io_mapper_props
  import adm_pkg::*;
#(
  parameter int unsigned MS_CYCLES_P     = 10,
  parameter int unsigned STROBE_CYCLES_P = 4
) (
  input wire logic               coreClk,
  input wire logic               rst,
  input wire logic               transientStart,
  input wire logic               paramChange,
  input wire logic               outputEnabled,
  input wire logic               frontPanelRelay,
  input wire logic [NUM_DIN-1:0] digInPin,
  input wire logic               remoteContactPin,
  input wire logic               trigInPin,
  input wire logic               relayDriveOutAOut,
  input wire logic               relayDriveOutBOut,
  input wire logic               strobeOut,
  input wire logic [NUM_DIN-1:0] actRise,
  input wire logic [NUM_DIN-1:0] actFall,
  input wire logic               relayClose,
  input wire logic               trigRun
);
  int unsigned stbLen;
  logic        evtQ;
  logic        outEnQ;

  default clocking cb @(posedge coreClk); endclocking
  default disable iff (rst);

  // strobe high length and the event seen one cycle earlier
  always_ff @(posedge coreClk) begin
    if (rst) begin
      stbLen <= 0;
      evtQ   <= 1'b0;
      outEnQ <= 1'b0;
    end else begin
      stbLen <= strobeOut ? stbLen + 1 : 0;
      evtQ   <= transientStart | paramChange | (outputEnabled & ~outEnQ);
      outEnQ <= outputEnabled;
    end
  end

  sequence s_trig_edge;
    !trigInPin ##1 trigInPin;
  endsequence
  sequence s_contact(logic v);
    (remoteContactPin == v) [*3];
  endsequence

  property p_od_low; !relayDriveOutAOut && !relayDriveOutBOut; endproperty
  property p_act_once;
    (actRise & $past(actRise)) == '0 && (actFall & $past(actFall)) == '0;
  endproperty
  property p_rise_src; (actRise & ~$past(digInPin, 3)) == '0; endproperty
  property p_fall_src; (actFall & $past(digInPin, 3)) == '0; endproperty
  property p_rise_fall; (actRise & actFall) == '0; endproperty
  property p_stb_width; $fell(strobeOut) |-> stbLen >= STROBE_CYCLES_P;
  endproperty
  property p_stb_cause; $rose(strobeOut) |-> evtQ; endproperty
  property p_trig_src;
    trigRun |-> $past(trigInPin, 3) && !$past(trigInPin, 4);
  endproperty
  property p_trig_once; trigRun |=> !trigRun; endproperty
  property p_relay_off;
    s_contact(1'b0) ##1 !frontPanelRelay |=> !relayClose;
  endproperty
  property p_relay_on;
    s_contact(1'b1) ##1 frontPanelRelay |=> relayClose;
  endproperty

  a_od_low: assert property (p_od_low)
    else $error("open-drain data not low");
  a_act_once: assert property (p_act_once)
    else $error("edge request longer than one cycle");
  a_rise_src: assert property (p_rise_src)
    else $error("rise request without high input");
  a_fall_src: assert property (p_fall_src)
    else $error("fall request without low input");
  a_rise_fall: assert property (p_rise_fall)
    else $error("rise and fall together");
  a_stb_width: assert property (p_stb_width)
    else $error("strobe too short");
  a_stb_cause: assert property (p_stb_cause)
    else $error("strobe without event");
  a_trig_src: assert property (p_trig_src)
    else $error("trigger run without pin edge");
  a_trig_once: assert property (p_trig_once)
    else $error("trigger run longer than one cycle");
  a_relay_off: assert property (p_relay_off)
    else $error("relay closed with no request");
  a_relay_on: assert property (p_relay_on)
    else $error("relay open with both requests");
  c_trig: cover property (s_trig_edge ##3 trigRun);
endmodule // adm_io_mapper_props

bind adm_io_mapper adm_io_mapper_props #(
  .MS_CYCLES_P    (MS_CYCLES_P),
  .STROBE_CYCLES_P(STROBE_CYCLES_P)
) props_u (.*);

// ==== bench/adm_ext_equip.sv ====
/*
  adm_ext_equip: far-side equipment; drives input pins, relay coils on
  the open-drain pins with pull-ups.
  assumes pins change right after a core clock edge.
*/
`timescale 1ns/1ps
module adm_ext_equip (
  input  wire logic       coreClk,
  input  wire logic       aOeN,
  input  wire logic       aOut,
  input  wire logic       bOeN,
  input  wire logic       bOut,
  output logic      [4:0] pins,
  output logic            aPin,
  output logic            bPin
);
  // pull-up holds a released pin high
  assign aPin = aOeN ? 1'b1 : aOut;
  assign bPin = bOeN ? 1'b1 : bOut;
  initial pins = 5'h00;
  task setp(input int i, input logic v);
    @(posedge coreClk);
    pins[i] <= v;
  endtask
  task pulse(input int i, input int len);
    setp(i, 1'b1);
    repeat (len) @(posedge coreClk);
    setp(i, 1'b0);
    repeat (len) @(posedge coreClk);
  endtask
endmodule // adm_ext_equip

// ==== bench/tb_adm_io_mapper.sv ====
/*
  tb_adm_io_mapper: self-checking bench with register and pin models.
  assumes short ms and strobe counts set through parameters.
*/
`timescale 1ns/1ps
module tb_adm_io_mapper;
  import adm_pkg::*;
  localparam int STC = 4;
  logic coreClk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [3:0] pstrb, ev;
  logic [31:0] pwdata, prdata, seed, rd, v, cfg, regM[6];
  logic faultActive, singlePhase, outputEnabled, programActive;
  logic remoteActive, transientActive, transformerCoupled;
  logic transientStart, paramChange, frontPanelRelay, transientArmed;
  logic [4:0] pinBus;
  logic [2:0] digInPin, actRise, actFall;
  logic remoteContactPin, trigInPin, logicLevelOutA, logicLevelOutB;
  logic relayDriveOutAIn, relayDriveOutAOut, relayDriveOutAOeN;
  logic relayDriveOutBIn, relayDriveOutBOut, relayDriveOutBOeN;
  logic strobeOut, relayClose, trigRun, trigSkipPhase;
  logic [11:0] riseAction, fallAction;
  int errors, nCompared, cycles, stbN, trigN, stbLen, n0;
  int riseN[3], fallN[3];

  adm_io_mapper #(.MS_CYCLES_P(10), .STROBE_CYCLES_P(STC)) dut_u (.*);
  adm_ext_equip ext_u (.coreClk(coreClk), .pins(pinBus),
    .aOeN(relayDriveOutAOeN), .aOut(relayDriveOutAOut),
    .aPin(relayDriveOutAIn), .bOeN(relayDriveOutBOeN),
    .bOut(relayDriveOutBOut), .bPin(relayDriveOutBIn));
  assign digInPin = pinBus[2:0];
  assign trigInPin = pinBus[3];
  assign remoteContactPin = pinBus[4];

  initial begin
    coreClk = 1'b0;
    forever #5 coreClk = ~coreClk;
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // output value from one config byte and the condition vector
  function logic outM(input logic [7:0] c, input logic [6:0] k);
    outM = c[4] ^ (c[3:0] == 4'h2 || (c[3:0] < 4'h2 && k[c[3:0]])
      || (c[3:0] > 4'h3 && c[3:0] < 4'h9 && k[c[3:0] - 4'h2]));
  endfunction

  task check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    nCompared++;
    if (seen !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task conclude();
    if (errors == 0 && nCompared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d,
           input logic [3:0] s);
    @(posedge coreClk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge coreClk);
    penable <= 1'b1;
    @(posedge coreClk);
    while (pready !== 1'b1) @(posedge coreClk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(a, 1'b1, d, s);
    for (int b = 0; b < 4; b++)
      if (s[b] && a < 8'h18) regM[a >> 2][8*b +: 8] = d[8*b +: 8];
  endtask
  task rdchk(input logic [7:0] a);
    apb(a, 1'b0, 32'h0, 4'h0);
    check("prdata", rd, a < 8'h18 ? regM[a >> 2] : 32'h0);
    check("pslverr", err, a > 8'h18);
  endtask
  task fire(input int k);
    @(posedge coreClk);
    {outputEnabled, paramChange, transientStart} <= 3'(1 << k);
    @(posedge coreClk);
    {outputEnabled, paramChange, transientStart} <= 3'h0;
    repeat (8) @(posedge coreClk);
  endtask

  always @(posedge coreClk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      conclude();
    end
    if (!rst) begin
      for (int i = 0; i < 3; i++) begin
        riseN[i] += actRise[i];
        fallN[i] += actFall[i];
      end
      trigN += trigRun;
      if (strobeOut) stbLen++;
      else if (stbLen != 0) begin
        check("strobe width", stbLen, STC);
        stbN++;
        stbLen = 0;
      end
    end
  end

  initial begin
    seed = 32'h48;
    regM = '{32'h03030303, 0, 0, 0, 0, 0};
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {faultActive, singlePhase, outputEnabled, programActive} = '0;
    {remoteActive, transientActive, transformerCoupled} = '0;
    {transientStart, paramChange, frontPanelRelay, transientArmed} = '0;
    rst = 1'b1;
    repeat (4) @(posedge coreClk);
    rst <= 1'b0;
    for (int a = 0; a < 32; a += 4) if (a != 24) rdchk(8'(a));
    wr(8'h1c, 32'hffffffff, 4'hf);
    check("pslverr", err, 1'b1);
    wr(8'h00, 32'h1f1f1f1f, 4'h5);
    rdchk(8'h00);
    for (int f = 0; f < 18; f++) begin
      v = rnd();
      @(posedge coreClk);
      {transformerCoupled, transientActive, remoteActive, programActive,
       outputEnabled, singlePhase, faultActive} <= v[6:0];
      for (int i = 0; i < 4; i++)
        cfg[8*i +: 8] = {3'h0, v[8+i], 4'((f + 2*i) % 9)};
      wr(8'h00, cfg, 4'hf);
      repeat (2) @(negedge coreClk);
      for (int i = 0; i < 4; i++) ev[i] = outM(cfg[8*i +: 8], v[6:0]);
      check("outA", logicLevelOutA, ev[0]);
      check("outB", logicLevelOutB, ev[1]);
      check("relayAOeN", relayDriveOutAOeN, !ev[2]);
      check("relayBPin", relayDriveOutBIn, !ev[3]);
    end
    @(posedge coreClk);
    outputEnabled <= 1'b0;
    v = rnd() & 32'h00ffffff;
    wr(8'h10, v, 4'hf);
    wr(8'h08, 32'd2, 4'hf);
    wr(8'h0c, 32'd10000000, 4'hf);
    rdchk(8'h0c);
    check("riseAction", riseAction, {v[19:16], v[11:8], v[3:0]});
    check("fallAction", fallAction, {v[23:20], v[15:12], v[7:4]});
    ext_u.pulse(0, 5);
    ext_u.pulse(1, 8);
    ext_u.pulse(1, 60);
    ext_u.pulse(2, 60);
    repeat (40) @(negedge coreClk);
    for (int i = 0; i < 3; i++) begin
      check("rises", riseN[i], i < 2);
      check("falls", fallN[i], i < 2);
    end
    for (int o = 0; o < 3; o++) begin
      wr(8'h14, 32'(1 << o), 4'hf);
      n0 = stbN;
      for (int k = 0; k < 3; k++) fire(k);
      check("strobes", stbN - n0, 1);
    end
    for (int m = 0; m < 12; m++) begin
      wr(8'h14, 32'((m / 4) << 3), 4'hf);
      frontPanelRelay <= m[1];
      ext_u.setp(4, m[0]);
      repeat (6) @(negedge coreClk);
      check("relayClose", relayClose, m < 4 ? m[1] : m < 8 ?
        m[1] & m[0] : m[1] | m[0]);
    end
    for (int t = 0; t < 9; t++) begin
      wr(8'h14, 32'({t[1], t[0], t < 8} << 5), 4'hf);
      transientArmed <= t[2];
      n0 = trigN;
      ext_u.pulse(3, 4);
      repeat (4) @(negedge coreClk);
      check("trigRuns", trigN - n0, t < 8 && (t[0] || t[2]));
      if (trigN != n0) check("skip", trigSkipPhase, t[1]);
    end
    conclude();
  end
endmodule // tb_adm_io_mapper
